// ---- design/ssp_link_if.sv ----
`timescale 1ns/1ps
interface ssp_link_if;
  logic rst;
  logic en_slave;
  logic ss_use;
  logic ss_pin;
  logic serial_in_pin;
  logic [7:0] tx_hold;
  logic [7:0] rx_word;
  logic done_tgl;
  logic out_bit;

  modport ctrl (
    output rst, en_slave, ss_use, ss_pin, serial_in_pin, tx_hold,
    input rx_word, done_tgl, out_bit
  );

  modport link (
    input rst, en_slave, ss_use, ss_pin, serial_in_pin, tx_hold,
    output rx_word, done_tgl, out_bit
  );
endinterface

// ---- design/ssp_pkg.sv ----
package ssp_pkg;

  localparam int SSP_WORD_BITS = 8;
  localparam logic [3:0] SSP_LAST_BIT = 4'h8;
  localparam logic [4:0] SSP_LAST_TICK = 5'h10;
  localparam logic [7:0] SSP_BUF_RST = 8'h00;

  // Half periods of the master serial clock, in main clock cycles, per rate code.
  localparam logic [7:0] SSP_HALF_DIV0 = 8'h04;
  localparam logic [7:0] SSP_HALF_DIV1 = 8'h10;
  localparam logic [7:0] SSP_HALF_DIV2 = 8'h40;
  localparam logic [7:0] SSP_HALF_DIV3 = 8'h80;

  typedef enum logic {
    SSP_IDLE,
    SSP_RUN
  } ssp_state_t;

endpackage

// ---- design/ssp_serial_port.sv ----
`timescale 1ns/1ps
// Functional notes
// - Each transfer shifts eight bits out and eight in together, on the serial clock.
// - All four clock polarity and output edge combinations are supported.
// - Incoming data is sampled in the middle or at the end of output time.
// - Master drives the serial clock; slave takes it as an input.
// - Clock rate matters only as master; slave select only as slave.
// - An optional slave select line is used only in slave role.
// - The port works only while its enable bit is set; enable claims pins.
// - The serial input pin direction is controlled by the port itself.
// - An unwanted serial pin function is cut by the opposite direction bit, except serial input, which an enabled port forces to input.
// - As master the port may start a transfer only while idle; a write during a word is dropped.
// - As master a buffer write starts sending and receiving at once.
// - With data out set as input, reception still runs at the clock rate.
// - A complete word reaches the buffer with flag and status updated unless the buffer is still full.
// - Direction bit one floats the pin; zero drives the output latch.
// - An enabled peripheral forces the serial input pin to input; clock follows its direction bit, data out too unless an inactive slave select floats it.
// - A complete word moves to the buffer and sets the interrupt flag.
// - A word completing before the buffer is read sets overflow and is lost.
module ssp_serial_port import ssp_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_port_enable_bit,
  input wire logic i_master_role,
  input wire logic i_clk_idle_high,
  input wire logic i_clk_edge_sel,
  input wire logic i_sample_end,
  input wire logic [1:0] i_clk_rate,
  input wire logic i_slave_select_use,
  input wire logic i_buf_wr,
  input wire logic [7:0] i_buf_wdata,
  input wire logic i_buf_rd,
  input wire logic i_flag_clr,
  input wire logic i_ovf_clr,
  input wire logic i_wcol_clr,
  input wire logic i_dir_out,
  input wire logic i_dir_clk,
  input wire logic i_dir_in,
  input wire logic i_latch_out,
  input wire logic i_latch_clk,
  input wire logic i_latch_in,
  input wire logic i_serial_in_pin,
  input wire logic i_sck_pin,
  input wire logic i_pin_a5,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe,
  output logic o_sck_out,
  output logic o_sck_oe,
  output logic o_serial_in_out,
  output logic o_serial_in_oe,
  output logic [7:0] o_transfer_buffer,
  output logic o_buffer_full,
  output logic o_port_interrupt_flag,
  output logic o_receive_overflow_bit,
  output logic o_write_collision,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers and declarations.

  function automatic logic [7:0] ssp_half_div(input logic [1:0] rate);
    logic [7:0] r;
    r = SSP_HALF_DIV0;
    unique case (rate)
      2'h0: r = SSP_HALF_DIV0;
      2'h1: r = SSP_HALF_DIV1;
      2'h2: r = SSP_HALF_DIV2;
      2'h3: r = SSP_HALF_DIV3;
    endcase
    return r;
  endfunction

  ssp_state_t state_r;
  logic [7:0] div_r;
  logic [4:0] tick_r;
  logic [3:0] rx_cnt_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic sck_r;
  logic master_done;
  logic div_hit;
  logic sample_tick;
  logic shift_tick;
  logic start;
  logic en;
  logic slave_en;
  logic sdi_s;
  logic ss_s;
  logic done_s;
  logic done_prev_r;
  logic slave_done;
  logic word_done;
  logic [7:0] word;
  logic accept;
  logic [7:0] tx_hold_r;
  logic slave_sel_r;
  logic sdo_r;
  logic link_clk;

  ssp_link_if lnk ();

  assign en = i_port_enable_bit;
  assign slave_en = en && !i_master_role;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the main clock domain.

  ssp_sync2 #(.W(3)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_serial_in_pin, i_pin_a5, lnk.done_tgl}),
    .o_sync({sdi_s, ss_s, done_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Master engine: clock divider, bit ticks, shift registers.

  // A write while idle starts a word at once; the master owns the clock.
  assign start = i_buf_wr && en && i_master_role && (state_r == SSP_IDLE);
  assign div_hit = (div_r == ssp_half_div(i_clk_rate) - 8'h01);

  // Ticks end half periods. Sampling sits one half period later when the
  // end of output time is chosen, so the last sample may fall on tick 16.
  assign sample_tick = div_hit && (tick_r[0] == (i_clk_edge_sel == i_sample_end)) &&
                       !(tick_r == 5'h00 && !i_clk_edge_sel) &&
                       (rx_cnt_r != SSP_LAST_BIT);
  assign shift_tick = div_hit && (tick_r < SSP_LAST_TICK) &&
                      (i_clk_edge_sel ? tick_r[0] : (!tick_r[0] && tick_r != 5'h00));
  assign master_done = (state_r == SSP_RUN) && div_hit && (tick_r == SSP_LAST_TICK);

  always_ff @(posedge i_mclk) begin
    if (i_rst || !en) begin
      state_r <= SSP_IDLE;
      div_r <= 8'h00;
      tick_r <= 5'h00;
    end else begin
      unique case (state_r)
        SSP_IDLE: begin
          div_r <= 8'h00;
          tick_r <= 5'h00;
          if (start) begin
            state_r <= SSP_RUN;
          end
        end
        SSP_RUN: begin
          if (div_hit) begin
            div_r <= 8'h00;
            if (tick_r == SSP_LAST_TICK) begin
              state_r <= SSP_IDLE;
            end else begin
              tick_r <= tick_r + 5'h01;
            end
          end else begin
            div_r <= div_r + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || !en) begin
      o_busy <= 1'b0;
    end else if (start) begin
      o_busy <= 1'b1;
    end else if (master_done) begin
      o_busy <= 1'b0;
    end
  end

  // The serial clock rests at the idle level and toggles on ticks 0 to 15.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sck_r <= 1'b0;
    end else if (state_r == SSP_IDLE) begin
      sck_r <= i_clk_idle_high;
    end else if (div_hit && tick_r < SSP_LAST_TICK) begin
      sck_r <= ~sck_r;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_r <= 8'h00;
    end else if (start) begin
      tx_r <= i_buf_wdata;
    end else if (state_r == SSP_RUN && shift_tick) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // The last sample may share its edge with the end of the word, so the
  // buffer takes the next value of the shift register, not the old one.
  assign rx_nxt = (state_r == SSP_RUN && sample_tick) ? {rx_r[6:0], sdi_s} : rx_r;

  // Reception runs whether or not the data out pin drives.
  always_ff @(posedge i_mclk) begin
    if (i_rst || start) begin
      rx_r <= 8'h00;
      rx_cnt_r <= 4'h0;
    end else if (state_r == SSP_RUN && sample_tick) begin
      rx_r <= rx_nxt;
      rx_cnt_r <= rx_cnt_r + 4'h1;
    end
  end

  // A write while a master word is in flight is dropped and flagged.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_write_collision <= 1'b0;
    end else if (i_buf_wr && en && i_master_role && state_r == SSP_RUN) begin
      o_write_collision <= 1'b1;
    end else if (i_wcol_clr) begin
      o_write_collision <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slave engine on the link clock.

  // The link clock is inverted when idle level and edge select are equal, so that its rising edge is the sampling edge.
  // Settings change only while the port is disabled, so no glitch reaches it.
  assign link_clk = i_sck_pin ^ ~(i_clk_idle_high ^ i_clk_edge_sel);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_hold_r <= 8'h00;
    end else if (i_buf_wr && !i_master_role) begin
      tx_hold_r <= i_buf_wdata;
    end
  end

  assign lnk.rst = i_rst;
  assign lnk.en_slave = slave_en;
  assign lnk.ss_use = i_slave_select_use;
  assign lnk.ss_pin = i_pin_a5;
  assign lnk.serial_in_pin = i_serial_in_pin;
  assign lnk.tx_hold = tx_hold_r;

  ssp_slave_link u_slave (
    .i_link_clk(link_clk),
    .lnk(lnk.link)
  );

  // The completion toggle crosses by two flops; the word stays stable a full word.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      done_prev_r <= 1'b0;
    end else begin
      done_prev_r <= done_s;
    end
  end

  assign slave_done = (done_s != done_prev_r) && slave_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer buffer and status.

  assign word_done = master_done || slave_done;
  assign word = i_master_role ? rx_nxt : lnk.rx_word;
  assign accept = word_done && (!o_buffer_full || i_buf_rd);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_transfer_buffer <= SSP_BUF_RST;
    end else if (accept) begin
      o_transfer_buffer <= word;
    end
  end

  // A new word wins over a read in the same cycle.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_buffer_full <= 1'b0;
    end else if (accept) begin
      o_buffer_full <= 1'b1;
    end else if (i_buf_rd) begin
      o_buffer_full <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_port_interrupt_flag <= 1'b0;
    end else if (accept) begin
      o_port_interrupt_flag <= 1'b1;
    end else if (i_flag_clr) begin
      o_port_interrupt_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_receive_overflow_bit <= 1'b0;
    end else if (word_done && !accept) begin
      o_receive_overflow_bit <= 1'b1;
    end else if (i_ovf_clr) begin
      o_receive_overflow_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers; the peripheral overrides the serial input direction bit, and an inactive slave select floats data out.

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_serial_out_oe <= 1'b0;
      sdo_r <= 1'b0;
      slave_sel_r <= 1'b0;
    end else if (en) begin
      o_serial_out_oe <= !i_dir_out && !(slave_en && i_slave_select_use && ss_s);
      sdo_r <= tx_r[7];
      slave_sel_r <= !i_master_role;
    end else begin
      o_serial_out_oe <= !i_dir_out;
      sdo_r <= i_latch_out;
      slave_sel_r <= 1'b0;
    end
  end

  // The slave data bit moves on the link clock, so it bypasses the main clock.
  assign o_serial_out_pin = slave_sel_r ? lnk.out_bit : sdo_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sck_oe <= 1'b0;
      o_sck_out <= 1'b0;
    end else begin
      o_sck_oe <= !i_dir_clk;
      o_sck_out <= (en && i_master_role) ? sck_r : i_latch_clk;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_serial_in_oe <= 1'b0;
      o_serial_in_out <= 1'b0;
    end else begin
      o_serial_in_oe <= !en && !i_dir_in;
      o_serial_in_out <= i_latch_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_start_runs: assert property (@(posedge i_mclk) disable iff (i_rst)
    start |=> (state_r == SSP_RUN) && o_busy && (tx_r == $past(i_buf_wdata)))
    else $error("Buffer write as master did not start a word.");

  a_eight_bits: assert property (@(posedge i_mclk) disable iff (i_rst)
    master_done |-> ((rx_cnt_r + {3'h0, sample_tick}) == SSP_LAST_BIT))
    else $error("Master word finished without eight samples.");

  a_sck_idle_level: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r == SSP_IDLE) && $past(state_r == SSP_IDLE) && $stable(i_clk_idle_high)
    |-> sck_r == i_clk_idle_high)
    else $error("Serial clock not at idle level between words.");

  a_sdi_input: assert property (@(posedge i_mclk) disable iff (i_rst)
    en |=> !o_serial_in_oe)
    else $error("Serial input pin driven while port enabled.");

  a_flag_on_word: assert property (@(posedge i_mclk) disable iff (i_rst)
    accept |=> o_port_interrupt_flag && o_buffer_full && (o_transfer_buffer == $past(word)))
    else $error("Completed word not moved to buffer with flag.");

  a_overflow_keeps: assert property (@(posedge i_mclk) disable iff (i_rst)
    word_done && o_buffer_full && !i_buf_rd
    |=> o_receive_overflow_bit && $stable(o_transfer_buffer))
    else $error("Overflow not flagged or buffer overwritten.");

  a_dir_floats: assert property (@(posedge i_mclk) disable iff (i_rst)
    !en && i_dir_out |=> !o_serial_out_oe)
    else $error("Data out driven with direction bit set.");

  a_select_quiet: assert property (@(posedge i_mclk) disable iff (i_rst)
    slave_en && i_slave_select_use && ss_s |=> !o_serial_out_oe)
    else $error("Data out driven while slave select inactive.");

  a_disable_stops: assert property (@(posedge i_mclk) disable iff (i_rst)
    !en |=> (state_r == SSP_IDLE) && !o_busy)
    else $error("Master engine running while disabled.");

endmodule // ssp_serial_port

// ---- design/ssp_slave_link.sv ----
`timescale 1ns/1ps
module ssp_slave_link import ssp_pkg::*; (
  input wire logic i_link_clk,
  ssp_link_if.link lnk
);

  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic done_r;
  logic hold;

  // With slave select in use and high, clock edges are ignored.
  assign hold = !lnk.en_slave || (lnk.ss_use && lnk.ss_pin);

  // The rising edge of the link clock is always the sampling edge.
  always_ff @(posedge i_link_clk or posedge lnk.rst) begin
    if (lnk.rst) begin
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      rx_r <= 8'h00;
      done_r <= 1'b0;
    end else if (hold) begin
      cnt_r <= 3'h0;
    end else begin
      sh_r <= {sh_r[6:0], lnk.serial_in_pin};
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h7) begin
        rx_r <= {sh_r[6:0], lnk.serial_in_pin};
        done_r <= ~done_r;
      end
    end
  end

  // Output data moves on the other edge, from the second bit onward.
  always_ff @(negedge i_link_clk or posedge lnk.rst) begin
    if (lnk.rst) begin
      tx_r <= 8'h00;
    end else if (cnt_r == 3'h1) begin
      tx_r <= {lnk.tx_hold[6:0], 1'b0};
    end else begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  assign lnk.out_bit = (cnt_r == 3'h0) ? lnk.tx_hold[7] : tx_r[7];
  assign lnk.rx_word = rx_r;
  assign lnk.done_tgl = done_r;

endmodule // ssp_slave_link

// ---- design/ssp_sync2.sv ----
`timescale 1ns/1ps
module ssp_sync2 #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // The first stage feeds the second stage only.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // ssp_sync2

// ---- verification/spi_serial_port_tb_top.sv ----
`timescale 1ns/1ps
module spi_serial_port_tb_top;
  import ssp_pkg::*;
  logic clk, rst, en, mst, cpol, edg, smp, ssu, wr, rd, fc, oc, wc;
  logic dir_o, dir_c, dir_i, lat_o, lat_c, lat_i;
  logic serial_out_pin, sdo_oe, sck_o, sck_oe, sdi_o, sdi_oe, full, flag, ovf, wcol, busy;
  logic sck_w, sdi_w, sdo_w, far_sck, far_ss_n, far_d;
  logic [1:0] rate;
  logic [7:0] wd, tx, rx, buf_q, far_rx;
  int err_total, check_count, seed, n, lat;
  assign sck_w = sck_oe ? sck_o : far_sck;
  assign sdi_w = sdi_oe ? sdi_o : far_d;
  assign sdo_w = sdo_oe ? serial_out_pin : ~serial_out_pin;

  ssp_serial_port uut (
    .i_mclk(clk), .i_rst(rst), .i_port_enable_bit(en), .i_master_role(mst),
    .i_clk_idle_high(cpol), .i_clk_edge_sel(edg), .i_sample_end(smp),
    .i_clk_rate(rate), .i_slave_select_use(ssu), .i_buf_wr(wr), .i_buf_wdata(wd),
    .i_buf_rd(rd), .i_flag_clr(fc), .i_ovf_clr(oc), .i_wcol_clr(wc),
    .i_dir_out(dir_o), .i_dir_clk(dir_c), .i_dir_in(dir_i), .i_latch_out(lat_o),
    .i_latch_clk(lat_c), .i_latch_in(lat_i), .i_serial_in_pin(sdi_w),
    .i_sck_pin(sck_w), .i_pin_a5(far_ss_n),
    .o_serial_out_pin(serial_out_pin), .o_serial_out_oe(sdo_oe), .o_sck_out(sck_o),
    .o_sck_oe(sck_oe), .o_serial_in_out(sdi_o), .o_serial_in_oe(sdi_oe),
    .o_transfer_buffer(buf_q), .o_buffer_full(full), .o_port_interrupt_flag(flag),
    .o_receive_overflow_bit(ovf), .o_write_collision(wcol), .o_busy(busy)
  );

  ssp_far_model far (
    .i_cpol(cpol), .i_cpha(~edg), .i_sck(sck_w), .i_data(sdo_w),
    .o_sck(far_sck), .o_ss_n(far_ss_n), .o_data(far_d), .o_rx(far_rx)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic int lat_of(input logic [1:0] r);
    logic [7:0] h;
    h = r[1] ? (r[0] ? SSP_HALF_DIV3 : SSP_HALF_DIV2) : (r[0] ? SSP_HALF_DIV1 : SSP_HALF_DIV0);
    return 17 * int'(h);
  endfunction

  task automatic cfg(input logic m, input logic [2:0] md, input logic [1:0] r, input logic s);
    @(negedge clk) en = 1'b0;
    @(negedge clk) {mst, cpol, edg, smp, rate, ssu, dir_c} = {m, md, r, s, ~m};
    @(negedge clk) en = 1'b1;
  endtask

  task automatic put(input logic [7:0] w);
    @(negedge clk) {wr, wd} = {1'b1, w};
    @(negedge clk) wr = 1'b0;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(negedge clk) {rd, fc, oc, wc} = m;
    @(negedge clk) {rd, fc, oc, wc} = 4'h0;
  endtask

  task automatic wait_flag(input int start);
    n = start;
    while (flag !== 1'b1 && ovf !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        err_total++;
        $display("[FAIL] flag wait expected 1 seen 0");
        summarize();
      end
    end
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 32'h6DF7B16A;
    {err_total, check_count} = '0;
    {rst, en, mst, cpol, edg, smp, rate, ssu, wr, rd, fc, oc, wc, wd} = {1'b1, 21'h000000};
    {dir_o, dir_c, dir_i, lat_o, lat_c, lat_i} = 6'h0E;
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    @(negedge clk);
    check("reset buffer", buf_q, SSP_BUF_RST);
    check("reset status", {4'h0, busy, flag, ovf, wcol}, 8'h00);
    check("sck pin", {6'h00, sck_oe, sck_o}, 8'h03);
    check("sdo pin", {6'h00, sdo_oe, serial_out_pin}, 8'h03);
    check("sdi pin", {7'h00, sdi_oe}, 8'h00);
    put(8'hA5);
    repeat (3) @(negedge clk);
    check("off busy", {7'h00, busy}, 8'h00);
    $display("test pins done");
    for (int m = 0; m < 8; m++) begin
      cfg(1'b1, m[2:0], m[1:0], 1'b0);
      tx = (m == 0) ? 8'h01 : 8'($random(seed));
      rx = (m == 0) ? 8'h80 : 8'($random(seed));
      put(tx);
      far.start(rx);
      @(negedge clk);
      check("busy", {7'h00, busy}, 8'h01);
      wait_flag(1);
      lat = lat_of(rate);
      check("latency", {7'h00, n >= lat - 1 && n <= lat + 1}, 8'h01);
      check("m rx", buf_q, rx);
      check("m tx", far_rx, tx);
      check("m sck oe", {7'h00, sck_oe}, 8'h01);
      far.finish();
      pulse(4'hC);
    end
    $display("test master done");
    cfg(1'b1, 3'h1, 2'h0, 1'b0);
    put(8'hC3);
    far.start(8'h3C);
    repeat (3) @(negedge clk);
    put(8'h99);
    check("collision", {7'h00, wcol}, 8'h01);
    wait_flag(0);
    far.finish();
    pulse(4'h4);
    put(8'h0F);
    far.start(8'h66);
    wait_flag(0);
    check("ovf", {7'h00, ovf}, 8'h01);
    check("ovf buffer", buf_q, 8'h3C);
    check("ovf tx", far_rx, 8'h0F);
    far.finish();
    pulse(4'hF);
    check("clear", {5'h00, ovf, wcol, flag}, 8'h00);
    $display("test overflow done");
    dir_o = 1'b1;
    far.start(8'hE7);
    put(8'h18);
    @(negedge clk);
    check("rx only oe", {7'h00, sdo_oe}, 8'h00);
    wait_flag(1);
    check("rx only", buf_q, 8'hE7);
    far.finish();
    pulse(4'hC);
    dir_o = 1'b0;
    $display("test receive only done");
    for (int m = 0; m < 4; m++) begin
      cfg(1'b0, {m[1:0], 1'b0}, 2'h3, 1'b1);
      tx = 8'($random(seed));
      rx = (m == 3) ? 8'hFF : 8'($random(seed));
      put(tx);
      repeat (4) @(negedge clk);
      check("s sck oe", {7'h00, sck_oe}, 8'h00);
      check("s sdo idle", {7'h00, sdo_oe}, 8'h00);
      far.drive(8'h00, 1'b0);
      repeat (6) @(negedge clk);
      check("s ignored", {7'h00, flag}, 8'h00);
      far.drive(rx, 1'b1);
      wait_flag(0);
      check("s rx", buf_q, rx);
      check("s tx", far_rx, tx);
      pulse(4'hC);
    end
    $display("test slave done");
    summarize();
  end
endmodule // spi_serial_port_tb_top

// ---- verification/ssp_far_model.sv ----
`timescale 1ns/1ps
module ssp_far_model (
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic i_sck,
  input wire logic i_data,
  output logic o_sck,
  output logic o_ss_n,
  output logic o_data,
  output logic [7:0] o_rx
);
  logic [7:0] sh;
  logic act;
  logic ph;
  int ob;
  int ns;
  assign o_sck = i_cpol ^ ph;
  initial begin
    {ph, act, o_ss_n, o_data} = 4'h2;
    o_rx = 8'h00;
  end
  ////////////////////////////////////////
  // With leading-edge sampling the first bit has to sit on the line before any edge.
  task automatic start(input logic [7:0] w);
    sh = w;
    o_rx = 8'h00;
    ns = 0;
    ob = i_cpha ? 0 : 1;
    act = 1'b1;
    if (!i_cpha) o_data = w[7];
  endtask
  // A released line shows the inverse of its last level, never a held copy.
  task automatic finish();
    act = 1'b0;
    o_data = ~o_data;
  endtask
  // Runs a frame as clock owner; without select only three stray clocks are sent.
  task automatic drive(input logic [7:0] w, input logic sel);
    o_ss_n = ~sel;
    if (sel) start(w);
    // The port enables its data out only after select passes its synchroniser.
    #160;
    repeat (sel ? 8 : 3) begin
      #6 ph = 1'b1;
      #6 ph = 1'b0;
    end
    #6 o_ss_n = 1'b1;
    if (sel) finish();
  endtask
  ////////////////////////////////////////
  always @(i_sck) begin
    if (act && ns < 8) begin
      if ((i_sck != i_cpol) != i_cpha) begin
        o_rx = {o_rx[6:0], i_data};
        ns++;
      end else if (ob < 8) begin
        o_data = sh[7 - ob];
        ob++;
      end
    end
  end
endmodule // ssp_far_model
